// ===== ibps_cmdr.sv
`timescale 1ns/100ps
// Commander model: drives the register bus and acknowledges events
module ibps_cmdr (
    input  wire logic        clock,
    output logic      [3:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    input  wire logic        evt_valid,
    output logic             evt_taken
);
    logic [2:0] delay_ff;

    // Idle bus at time zero
    initial begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        evt_taken = 1'b0;
        delay_ff = 3'h0;
    end

    // One transfer; request held until waitrequest is seen low
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        int n;
        ok = 1'b0;
        q = 32'h0;
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        for (n = 0; n < 64; n++) begin
            @(posedge clock);
            if (avs_waitrequest === 1'b0) begin
                q = avs_readdata;
                ok = 1'b1;
                break;
            end
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : xfer

    // Ack after a random delay so both prompt and slow takers are seen
    always @(posedge clock) begin
        if (evt_valid !== 1'b1 || evt_taken) begin
            evt_taken <= 1'b0;
            delay_ff <= 3'($urandom % 6);
        end else if (delay_ff == 3'h0) begin
            evt_taken <= 1'b1;
        end else begin
            delay_ff <= delay_ff - 3'h1;
        end
    end
endmodule : ibps_cmdr

// ===== ibps_evt_gen.sv
`timescale 1ns/100ps
// Turns the service-need level into true/false events, one per edge
module ibps_evt_gen
    import ibps_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   nrst,
    input  wire logic   need,
    input  wire logic   master_cap,
    input  wire logic   async_ovr,
    input  wire logic   async_sig,
    ibps_evt_if.src     evt
);
    logic sent_ff;
    logic raise_ff;
    logic mode_ff;
    logic [7:0] code_ff;

    assign evt.raise    = raise_ff;
    assign evt.mode_sig = mode_ff;
    assign evt.code     = code_ff;

    // A new event only after the last one was taken
    always_ff @(posedge clock) begin
        if (!nrst) begin
            sent_ff  <= 1'b0;
            raise_ff <= 1'b0;
            mode_ff  <= 1'b0;
            code_ff  <= 8'h00;
        end else if (raise_ff) begin
            if (evt.ack) raise_ff <= 1'b0;
        end else if (need != sent_ff) begin
            raise_ff <= 1'b1;
            sent_ff  <= need;
            code_ff  <= need ? EVT_REQ_TRUE : EVT_REQ_FALSE;
            mode_ff  <= async_ovr ? async_sig : master_cap;
        end
    end

    a_false_follows: assert property (@(posedge clock) disable iff (!nrst)
        (raise_ff && code_ff == EVT_REQ_TRUE && evt.ack && !need) |=> ##[1:2] raise_ff
    ) else $error("request false not sent after need cleared");
endmodule : ibps_evt_gen

// ===== ibps_evt_if.sv
`timescale 1ns/100ps
interface ibps_evt_if;
    logic       raise;
    logic       mode_sig;
    logic [7:0] code;
    logic       ack;
    modport src (output raise, output mode_sig, output code, input ack);
    modport snk (input raise, input mode_sig, input code, output ack);
endinterface : ibps_evt_if

// ===== ibps_pkg.sv
package ibps_pkg;
    // Avalon register word addresses (word index)
    localparam logic [3:0]  ADDR_CMD      = 4'h0;
    localparam logic [3:0]  ADDR_RESP     = 4'h1;
    localparam logic [3:0]  ADDR_DATA_LOW = 4'h2;
    localparam logic [3:0]  ADDR_IN_DATA  = 4'h3;
    localparam logic [3:0]  ADDR_OUT_DATA = 4'h4;
    localparam logic [3:0]  ADDR_CTRL     = 4'h5;
    localparam logic [3:0]  ADDR_STB      = 4'h6;
    // Command word opcode field, bits 15:8
    localparam int          OPC_HI        = 15;
    localparam int          OPC_LO        = 8;
    localparam int          END_BIT       = 8;
    localparam logic [7:0]  OPC_BYTE_AVL  = 8'hBC;
    localparam logic [7:0]  OPC_BYTE_AVLE = 8'hBD;
    localparam logic [7:0]  OPC_BYTE_REQ  = 8'hDE;
    localparam logic [7:0]  OPC_CLEAR     = 8'hFF;
    localparam logic [7:0]  OPC_TRIGGER   = 8'hED;
    localparam logic [7:0]  OPC_SET_LOCK  = 8'hEF;
    localparam logic [7:0]  OPC_CLR_LOCK  = 8'hEE;
    localparam logic [7:0]  OPC_STATUS_BYTE_READ_CMD  = 8'hCF;
    localparam logic [7:0]  OPC_BNO       = 8'hFC;
    localparam logic [7:0]  OPC_ASYNC_MC  = 8'hA8;
    // Response register bit positions
    localparam int          RB_LOCKED_N   = 7;
    localparam int          RB_OUT_RDY    = 5;
    localparam int          RB_DIR        = 4;
    localparam int          RB_ERR_N      = 3;
    localparam int          RB_READ_RDY   = 2;
    localparam int          RB_WRITE_RDY  = 1;
    // Status byte service bit
    localparam int          STB_SVC_BIT   = 6;
    // Control register bits
    localparam int          CB_OUT_PUSH   = 0;
    localparam int          CB_SVC_NEED   = 1;
    localparam int          CB_MASTER_CAP = 2;
    localparam int          CB_ERR_EVT    = 3;
    localparam int          CB_IN_POP     = 4;
    localparam int          CB_TRIG_BUSY  = 5;
    // Event codes for the request events
    localparam logic [7:0]  EVT_REQ_TRUE  = 8'hFD;
    localparam logic [7:0]  EVT_REQ_FALSE = 8'hFC;
    // Dispatch states
    typedef enum logic [1:0] {
        IBPS_IDLE  = 2'b00,
        IBPS_EXEC  = 2'b01,
        IBPS_REPLY = 2'b11
    } ibps_state_t;
endpackage : ibps_pkg

// ===== ibps_servant.sv
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
module ibps_servant
    import ibps_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             local_enable,
    output logic             trigger_pulse,
    output logic             evt_valid,
    output logic             evt_as_signal,
    output logic      [7:0]  evt_code,
    input  wire logic        evt_taken
);
    ibps_state_t state_ff;
    logic        normal_ff;     // Normal operation reached
    logic        btp_en_ff;     // Byte transfer protocol active
    logic        dir_ff;
    logic        out_rdy_ff;
    logic        locked_n_ff;
    logic        read_rdy_ff;
    logic        err_n_ff;
    logic [15:0] cmd_ff;
    logic [15:0] reply_ff;      // Data low register
    logic [8:0]  in_data_ff;    // Received byte plus end
    logic        in_full_ff;
    logic [8:0]  out_data_ff;   // Queued output byte plus end
    logic        out_full_ff;
    logic [7:0]  stb_ff;
    logic [5:0]  ctrl_ff;
    logic        async_ovr_ff;
    logic        async_sig_ff;
    logic        wait_ff;
    logic [31:0] rdata_ff;
    logic        trig_ff;
    logic        local_ff;

    logic        acc;
    logic        wr_cmd;
    logic        wr_ctrl;
    logic [7:0]  opc;
    logic        hold_off;
    logic        svc_need;

    ibps_evt_if evt_bus ();

    assign acc      = (avs_read || avs_write) && wait_ff;
    assign wr_cmd   = acc && avs_write && avs_address == ADDR_CMD && avs_byteenable[1];
    assign wr_ctrl  = acc && avs_write && avs_address == ADDR_CTRL && avs_byteenable[0];
    assign opc      = cmd_ff[OPC_HI:OPC_LO];
    // Input full or trigger busy stalls new byte data
    assign hold_off = in_full_ff || ctrl_ff[CB_TRIG_BUSY];
    assign svc_need = ctrl_ff[CB_SVC_NEED] || !err_n_ff;

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign local_enable    = local_ff;
    assign trigger_pulse   = trig_ff;
    assign evt_valid       = evt_bus.raise;
    assign evt_as_signal   = evt_bus.mode_sig;
    assign evt_code        = evt_bus.code;
    assign evt_bus.ack     = evt_taken;

    // Waitrequest high by default; drops for one cycle to finish a request
    always_ff @(posedge clock) begin
        if (!nrst) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= !(wait_ff && (avs_read || avs_write));
        end
    end

    // Read data mux; unmapped words read zero
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (acc && avs_read) begin
            unique case (avs_address)
                ADDR_RESP:     rdata_ff <= {24'h00_0000, locked_n_ff, 1'b0, out_rdy_ff, dir_ff,
                                            err_n_ff, read_rdy_ff, state_ff == IBPS_IDLE, 1'b0};
                ADDR_DATA_LOW: rdata_ff <= {16'h0000, reply_ff};
                ADDR_IN_DATA:  rdata_ff <= {22'h00_0000, in_full_ff, in_data_ff};
                ADDR_OUT_DATA: rdata_ff <= {22'h00_0000, out_full_ff, out_data_ff};
                ADDR_CTRL:     rdata_ff <= {26'h000_0000, ctrl_ff};
                ADDR_STB:      rdata_ff <= {24'h00_0000, stb_ff};
                default:       rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Reading data low consumes a reply
    always_ff @(posedge clock) begin
        if (!nrst) begin
            read_rdy_ff <= 1'b0;
        end else if (state_ff == IBPS_REPLY) begin
            read_rdy_ff <= 1'b1;
        end else if (acc && avs_read && avs_address == ADDR_DATA_LOW) begin
            read_rdy_ff <= 1'b0;
        end
    end

    // Control and status byte written by the instrument core side
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctrl_ff      <= 6'h00;
            stb_ff       <= 8'h00;
        end else begin
            if (wr_ctrl) ctrl_ff <= avs_writedata[5:0];
            else ctrl_ff[CB_IN_POP] <= 1'b0; // Pop strobes self clear
            if (wr_ctrl) ctrl_ff[CB_OUT_PUSH] <= avs_writedata[CB_OUT_PUSH];
            else ctrl_ff[CB_OUT_PUSH] <= 1'b0;
            if (acc && avs_write && avs_address == ADDR_STB && avs_byteenable[0])
                stb_ff <= avs_writedata[7:0];
        end
    end

    // Command capture and dispatch
    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_ff <= IBPS_IDLE;
            cmd_ff   <= 16'h0000;
        end else begin
            unique case (state_ff)
                IBPS_IDLE:  if (wr_cmd) begin
                    cmd_ff   <= avs_writedata[15:0];
                    state_ff <= IBPS_EXEC;
                end
                IBPS_EXEC:  begin
                    // Byte data waits while input is full; other commands proceed
                    if (!((opc == OPC_BYTE_AVL || opc == OPC_BYTE_AVLE) && hold_off))
                        state_ff <= (opc == OPC_BYTE_REQ || opc == OPC_STATUS_BYTE_READ_CMD)
                                    ? IBPS_REPLY : IBPS_IDLE;
                end
                IBPS_REPLY: state_ff <= IBPS_IDLE;
            endcase
        end
    end

    wire exec_go = state_ff == IBPS_EXEC;

    // Protocol state: normal operation, byte transfer enable
    always_ff @(posedge clock) begin
        if (!nrst) begin
            normal_ff <= 1'b0;
            btp_en_ff <= 1'b0;
        end else if (exec_go && opc == OPC_BNO) begin
            normal_ff <= 1'b1;
            btp_en_ff <= 1'b1;
        end
        // Clear leaves btp_en_ff untouched
    end

    // Input buffer and input full flag
    always_ff @(posedge clock) begin
        if (!nrst) begin
            in_data_ff <= 9'h000;
            in_full_ff <= 1'b0;
        end else if (exec_go && opc == OPC_CLEAR) begin
            in_full_ff <= 1'b0;
        end else if (exec_go && btp_en_ff && !hold_off &&
                     (opc == OPC_BYTE_AVL || opc == OPC_BYTE_AVLE)) begin
            in_data_ff <= {opc[0], cmd_ff[7:0]};
            in_full_ff <= 1'b1;
        end else if (ctrl_ff[CB_IN_POP]) begin
            in_full_ff <= 1'b0;
        end
    end

    // Input ready low while full or trigger busy
    always_ff @(posedge clock) begin
        if (!nrst) begin
            dir_ff <= 1'b1;
        end else if (exec_go && opc == OPC_CLEAR) begin
            dir_ff <= !ctrl_ff[CB_TRIG_BUSY];
        end else begin
            dir_ff <= !hold_off && !(exec_go && !hold_off &&
                      (opc == OPC_BYTE_AVL || opc == OPC_BYTE_AVLE));
        end
    end

    // Output queue; push data pending before ready shows output ready
    always_ff @(posedge clock) begin
        if (!nrst) begin
            out_data_ff <= 9'h000;
            out_full_ff <= 1'b0;
        end else if (exec_go && opc == OPC_CLEAR) begin
            out_full_ff <= 1'b0;
        end else if (ctrl_ff[CB_OUT_PUSH] && !out_full_ff) begin
            out_data_ff <= {ctrl_ff[CB_ERR_EVT], 8'h00} | {1'b0, stb_ff};
            out_full_ff <= 1'b1;
        end else if (exec_go && opc == OPC_BYTE_REQ) begin
            out_full_ff <= 1'b0;
        end
    end

    // Output ready drops at once when the queue is taken or cleared
    always_ff @(posedge clock) begin
        if (!nrst) out_rdy_ff <= 1'b0;
        else out_rdy_ff <= out_full_ff &&
                           !(exec_go && (opc == OPC_BYTE_REQ || opc == OPC_CLEAR));
    end

    // Reply word for byte request and status byte read
    always_ff @(posedge clock) begin
        if (!nrst) begin
            reply_ff <= 16'h0000;
        end else if (exec_go && opc == OPC_BYTE_REQ) begin
            reply_ff <= {7'h00, out_data_ff};
        end else if (exec_go && opc == OPC_STATUS_BYTE_READ_CMD) begin
            reply_ff <= {8'h00, stb_ff[7], evt_bus.raise || svc_need, stb_ff[5:0]};
        end
    end

    // Trigger strobe to instrument core
    always_ff @(posedge clock) begin
        if (!nrst) trig_ff <= 1'b0;
        else trig_ff <= exec_go && opc == OPC_TRIGGER && !ctrl_ff[CB_TRIG_BUSY];
    end

    // Lock state; both commands always present
    always_ff @(posedge clock) begin
        if (!nrst) begin
            locked_n_ff <= 1'b1;
            local_ff    <= 1'b1;
        end else if (exec_go && opc == OPC_SET_LOCK) begin
            locked_n_ff <= 1'b0;
            local_ff    <= 1'b0;
        end else if (exec_go && opc == OPC_CLR_LOCK) begin
            locked_n_ff <= 1'b1;
            local_ff    <= 1'b1;
        end
    end

    // Message error flag; set by core, cleared by clear command
    always_ff @(posedge clock) begin
        if (!nrst) err_n_ff <= 1'b1;
        else if (wr_ctrl && avs_writedata[CB_ERR_EVT]) err_n_ff <= 1'b0;
        else if (exec_go && opc == OPC_CLEAR) err_n_ff <= 1'b1;
    end

    // Async mode control selects event delivery
    always_ff @(posedge clock) begin
        if (!nrst) begin
            async_ovr_ff <= 1'b0;
            async_sig_ff <= 1'b0;
        end else if (exec_go && opc == OPC_ASYNC_MC) begin
            async_ovr_ff <= 1'b1;
            async_sig_ff <= cmd_ff[0];
        end
    end

    ibps_evt_gen ibps_evt_gen_inst (
        .clock      (clock),
        .nrst       (nrst),
        .need       (svc_need && normal_ff),
        .master_cap (ctrl_ff[CB_MASTER_CAP]),
        .async_ovr  (async_ovr_ff),
        .async_sig  (async_sig_ff),
        .evt        (evt_bus.src)
    );

    a_lock_sets: assert property (@(posedge clock) disable iff (!nrst)
        (exec_go && opc == OPC_SET_LOCK) |=> !locked_n_ff && !local_ff
    ) else $error("set lock failed");
    a_lock_holds: assert property (@(posedge clock) disable iff (!nrst)
        (!local_ff && !(exec_go && opc == OPC_CLR_LOCK)) |=> !local_ff
    ) else $error("local control re-enabled");
    a_clear_flags: assert property (@(posedge clock) disable iff (!nrst)
        (exec_go && opc == OPC_CLEAR) |=> !out_rdy_ff && !in_full_ff
    ) else $error("clear incomplete");
    a_hold_off: assert property (@(posedge clock) disable iff (!nrst)
        (exec_go && opc == OPC_BYTE_AVL && hold_off) |=> state_ff == IBPS_EXEC
    ) else $error("byte accepted while full");
    // Full input keeps input ready low so the Commander holds off
    a_full_blocks_in: assert property (@(posedge clock) disable iff (!nrst)
        (in_full_ff && !(exec_go && opc == OPC_CLEAR)) |=> !dir_ff
    ) else $error("input ready high while input full");
    a_btp_kept: assert property (@(posedge clock) disable iff (!nrst)
        (exec_go && opc == OPC_CLEAR) |=> btp_en_ff == $past(btp_en_ff)
    ) else $error("clear changed protocol");
    a_reply_ready: assert property (@(posedge clock) disable iff (!nrst)
        (exec_go && opc == OPC_BYTE_REQ) |=> ##1 read_rdy_ff
    ) else $error("byte request reply missing");
endmodule : ibps_servant

// ===== ibps_servant_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module ibps_servant_tb;
    import ibps_pkg::*;
    typedef struct { logic [31:0] e; logic [31:0] m; } ibps_rnote_t;
    typedef struct { logic [7:0] c; logic s; } ibps_enote_t;
    logic        clock;
    logic        nrst;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        local_enable;
    logic        trigger_pulse;
    logic        evt_valid;
    logic        evt_as_signal;
    logic [7:0]  evt_code;
    logic        evt_taken;
    int          n_fail = 0;
    int          compares = 0;
    int          trig_cnt = 0;
    int          i;
    int          n;
    logic [7:0]  d;
    logic [7:0]  b;
    logic        e;
    logic        cap;
    ibps_rnote_t rq[$];
    ibps_enote_t eq[$];

    ibps_servant ibps_servant_inst (.clock(clock), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .local_enable(local_enable),
        .trigger_pulse(trigger_pulse), .evt_valid(evt_valid), .evt_as_signal(evt_as_signal),
        .evt_code(evt_code), .evt_taken(evt_taken));
    ibps_cmdr ibps_cmdr_inst (.clock(clock), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .evt_valid(evt_valid), .evt_taken(evt_taken));

    // 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic test_done();
        $display("counts: %0d compares, %0d mismatches", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        logic [31:0] q;
        logic        ok;
        ibps_cmdr_inst.xfer(wr, a, wd, q, ok);
        if (!ok) begin
            n_fail++;
            $display("unexpected bus timeout at address %h", a);
            test_done();
        end
    endtask : bus

    // Read noted with its expectation; the monitor does the compare
    task automatic rd(input logic [3:0] a, input logic [31:0] ev, input logic [31:0] m);
        rq.push_back('{ev, m});
        bus(1'b0, a, 32'h0);
    endtask : rd

    // Poll the response register until every bit in need is set
    task automatic poll(input logic [31:0] need);
        logic [31:0] q;
        logic        ok;
        for (int k = 0; k < 40; k++) begin
            rq.push_back('{32'h0, 32'h0});
            ibps_cmdr_inst.xfer(1'b0, ADDR_RESP, 32'h0, q, ok);
            if (ok && (q & need) === need) return;
        end
        n_fail++;
        $display("unexpected response flags exp %h got %h", need, q);
        test_done();
    endtask : poll

    // Commander only sends when the matching ready flag stands with write ready
    task automatic cmd(input logic [7:0] opc, input logic [7:0] dat);
        logic [31:0] need;
        need = 32'h1 << RB_WRITE_RDY;
        if (opc == OPC_BYTE_AVL || opc == OPC_BYTE_AVLE || opc == OPC_TRIGGER)
            need |= 32'h1 << RB_DIR;
        if (opc == OPC_BYTE_REQ)
            need |= 32'h1 << RB_OUT_RDY;
        poll(need);
        bus(1'b1, ADDR_CMD, {16'h0, opc, dat});
        poll(32'h1 << RB_WRITE_RDY);
    endtask : cmd

    // Bounded wait for every noted event to show up
    task automatic drain();
        for (int k = 0; k < 300; k++) begin
            if (eq.size() == 0) return;
            @(posedge clock);
        end
        n_fail++;
        $display("unexpected missing events exp 0 got %0d", eq.size());
        test_done();
    endtask : drain

    // Output monitor: oldest note against each result as it appears
    always @(posedge clock) begin : mon
        ibps_rnote_t r;
        ibps_enote_t v;
        if (avs_read && avs_waitrequest === 1'b0) begin
            if (rq.size() > 0) begin
                r = rq.pop_front();
                `CHK("readdata", r.e & r.m, avs_readdata & r.m)
            end else begin
                n_fail++;
                $display("unexpected read note exp 1 got 0");
            end
        end
        if (evt_valid === 1'b1 && evt_taken) begin
            if (eq.size() > 0) begin
                v = eq.pop_front();
                `CHK("evt_code", v.c, evt_code)
                `CHK("evt_as_signal", v.s, evt_as_signal)
            end else begin
                n_fail++;
                $display("unexpected event exp none got %h", evt_code);
            end
        end
        if (trigger_pulse === 1'b1) trig_cnt++;
    end

    initial begin
        nrst = 1'b0;
        void'($urandom(95333));
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        cmd(OPC_BNO, 8'h00);
        rd(ADDR_RESP, 32'h9A, 32'hBE);
        $display("test ready flags done");
        // Random bytes in; last one left in to hold input full
        for (i = 0; i < 4; i++) begin
            d = 8'($urandom);
            e = 1'($urandom);
            cmd(e ? OPC_BYTE_AVLE : OPC_BYTE_AVL, d);
            rd(ADDR_IN_DATA, {22'h0, 1'b1, e, d}, 32'h3FF);
            rd(ADDR_RESP, 32'h0, 32'h10);
            if (i < 3) bus(1'b1, ADDR_CTRL, 32'h10);
        end
        cmd(OPC_STATUS_BYTE_READ_CMD, 8'h00);
        rd(ADDR_DATA_LOW, 32'h0, 32'h40);
        cmd(OPC_CLEAR, 8'h00);
        rd(ADDR_IN_DATA, 32'h0, 32'h200);
        rd(ADDR_RESP, 32'h9A, 32'hBE);
        cmd(OPC_BYTE_AVL, 8'h5A);
        rd(ADDR_IN_DATA, 32'h25A, 32'h3FF);
        bus(1'b1, ADDR_CTRL, 32'h10);
        $display("test input path done");
        b = 8'($urandom);
        bus(1'b1, ADDR_STB, {24'h0, b});
        // Error event raises a request true, as an interrupt without master
        eq.push_back('{EVT_REQ_TRUE, 1'b0});
        bus(1'b1, ADDR_CTRL, 32'h9);
        rd(ADDR_RESP, 32'h20, 32'h20);
        cmd(OPC_BYTE_REQ, 8'h00);
        rd(ADDR_DATA_LOW, {24'h0, b}, 32'hFF);
        rd(ADDR_RESP, 32'h0, 32'h24);
        bus(1'b1, ADDR_CTRL, 32'h1);
        eq.push_back('{EVT_REQ_FALSE, 1'b0});
        cmd(OPC_CLEAR, 8'h00);
        rd(ADDR_RESP, 32'h0, 32'h20);
        $display("test output path done");
        bus(1'b1, ADDR_CTRL, 32'h20);
        rd(ADDR_RESP, 32'h0, 32'h10);
        bus(1'b1, ADDR_CTRL, 32'h0);
        n = trig_cnt;
        cmd(OPC_TRIGGER, 8'h00);
        `CHK("trigger count", n + 1, trig_cnt)
        $display("test trigger done");
        cmd(OPC_SET_LOCK, 8'h00);
        rd(ADDR_RESP, 32'h0, 32'h80);
        `CHK("local_enable", 1'b0, local_enable)
        cmd(OPC_CLEAR, 8'h00);
        rd(ADDR_RESP, 32'h0, 32'h80);
        `CHK("local_enable", 1'b0, local_enable)
        cmd(OPC_CLR_LOCK, 8'h00);
        rd(ADDR_RESP, 32'h80, 32'h80);
        `CHK("local_enable", 1'b1, local_enable)
        $display("test lock done");
        // Signal with master, interrupt without, then override both ways
        for (i = 0; i < 4; i++) begin
            if (i >= 2) cmd(OPC_ASYNC_MC, {7'h00, i == 2});
            cap = (i == 0 || i == 3);
            eq.push_back('{EVT_REQ_TRUE, i == 0 || i == 2});
            bus(1'b1, ADDR_CTRL, {29'h0, cap, 2'b10});
            drain();
            cmd(OPC_STATUS_BYTE_READ_CMD, 8'h00);
            rd(ADDR_DATA_LOW, 32'h40, 32'h40);
            eq.push_back('{EVT_REQ_FALSE, i == 0 || i == 2});
            bus(1'b1, ADDR_CTRL, {29'h0, cap, 2'b00});
            drain();
        end
        $display("test events done");
        bus(1'b1, 4'hE, 32'hFFFF_FFFF);
        rd(4'hE, 32'h0, 32'hFFFF_FFFF);
        rd(4'hF, 32'h0, 32'hFFFF_FFFF);
        $display("test unmapped done");
        drain();
        test_done();
    end
endmodule : ibps_servant_tb
